// ---- logic/tmc_pkg.sv ----
// Purpose: Shared constants for the transmit modulation control block
// Assumes: APB with 32-bit data, byte addresses
// Notes:   Register bytes sit in the low bits of each word
package tmc_pkg;
   // Register word addresses (printed offsets are not all multiples of four)
   localparam logic [7:0]  TMC_IDX_OCP      = 8'h13;
   localparam logic [7:0]  TMC_IDX_TUNE_A   = 8'h5A;
   localparam logic [7:0]  TMC_IDX_TUNE_B   = 8'h5C;
   localparam logic [7:0]  TMC_IDX_BR_MSB   = 8'h03;
   localparam logic [7:0]  TMC_IDX_BR_LSB   = 8'h04;
   localparam logic [7:0]  TMC_IDX_FDEV_MSB = 8'h05;
   localparam logic [7:0]  TMC_IDX_FDEV_LSB = 8'h06;
   localparam logic [7:0]  TMC_IDX_CTRL     = 8'h02;
   localparam logic [7:0]  TMC_IDX_RAMP     = 8'h12;
   localparam logic [7:0]  TMC_IDX_LEVEL    = 8'h11;
   localparam logic [7:0]  TMC_IDX_STATUS   = 8'h10;
   // Reset values
   localparam logic [7:0]  TMC_RST_OCP      = 8'h1A;
   localparam logic [7:0]  TMC_RST_TUNE_A   = 8'h55;
   localparam logic [7:0]  TMC_RST_TUNE_B   = 8'h70;
   localparam logic [7:0]  TMC_RST_BR_MSB   = 8'h1A;
   localparam logic [7:0]  TMC_RST_BR_LSB   = 8'h0B;
   localparam logic [7:0]  TMC_RST_FDEV_MSB = 8'h00;
   localparam logic [7:0]  TMC_RST_FDEV_LSB = 8'h52;
   localparam logic [7:0]  TMC_RST_LEVEL    = 8'h9F;
   // High power tuning signature values
   localparam logic [7:0]  TMC_HP_TUNE_A    = 8'h5D;
   localparam logic [7:0]  TMC_HP_TUNE_B    = 8'h7C;
   // Field positions
   localparam int          TMC_CTRL_TX      = 0;
   localparam int          TMC_CTRL_CONT    = 1;
   localparam int          TMC_CTRL_OOK     = 2;
   localparam int          TMC_LVL_PA0      = 7;
   localparam int          TMC_LVL_PA1      = 6;
   localparam int          TMC_LVL_PA2      = 5;
   localparam int          TMC_OCP_ON       = 4;
   // Power offsets in dBm
   localparam logic signed [7:0] TMC_OFS_SINGLE = -8'sd18;
   localparam logic signed [7:0] TMC_OFS_COMB   = -8'sd14;
   localparam logic signed [7:0] TMC_OFS_HP     = -8'sd11;
   // Current limit: base and step in mA
   localparam logic [7:0]  TMC_OCP_BASE_MA  = 8'd45;
   localparam logic [7:0]  TMC_OCP_STEP_MA  = 8'd5;
   // Synthesizer step is reference / 2**18; step_divisor is 19 bits wide
   localparam int          TMC_SDM_BITS     = 19;
   localparam int          TMC_FDEV_BITS    = 14;
   localparam logic [3:0]  TMC_RAMP_STEPS   = 4'hF;
   // Amplifier path codes
   typedef enum logic [1:0] {
      TMC_PATH_OFF  = 2'b00,
      TMC_PATH_LOW  = 2'b01,
      TMC_PATH_ONE  = 2'b11,
      TMC_PATH_COMB = 2'b10
   } tmc_path_type;
endpackage

// ---- logic/tmc_bit_timer.sv ----
// Purpose: Bit period divider and bit clock generator
// Assumes: pclk stands in for the reference oscillator
// Notes:   Tick once per divisor cycles; divisor below 2 treated as 2
`timescale 1ns/1ps
`default_nettype none
module tmc_bit_timer
   import tmc_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  bit_tick,
   output logic                  bit_clk
);
   logic [DIV_W-1:0] count;
   wire  [DIV_W-1:0] limit = (divisor < DIV_W'(2)) ? DIV_W'(1) : divisor - DIV_W'(1);
   wire              wrap  = (count >= limit);
   wire  [DIV_W-1:0] half  = limit >> 1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count    <= '0;
         bit_tick <= 1'b0;
         bit_clk  <= 1'b0;
      end else begin
         count    <= (!run || wrap) ? '0 : count + DIV_W'(1);
         bit_tick <= run && wrap;
         bit_clk  <= run && (count > half);
      end
   end

   bit_tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
      bit_tick |=> !bit_tick) else $error("bit tick doubled");
endmodule
`default_nettype wire

// ---- logic/tmc_ramp.sv ----
// Purpose: Amplifier bias ramp for keyed operation
// Assumes: One ramp step per clock
// Notes:   With ramping off, bias steps directly
`timescale 1ns/1ps
`default_nettype none
module tmc_ramp
   import tmc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       key_on,
   input  wire logic       smooth,
   output logic [3:0]      bias
);
   wire [3:0] next_bias = !smooth ? (key_on ? TMC_RAMP_STEPS : 4'h0)
                        : (key_on && bias != TMC_RAMP_STEPS) ? bias + 4'h1
                        : (!key_on && bias != 4'h0) ? bias - 4'h1 : bias;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bias <= 4'h0;
      else bias <= next_bias;
   end

   ramp_one_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      smooth && $past(smooth) |-> (bias - $past(bias) == 4'h1) || ($past(bias) - bias == 4'h1)
      || bias == $past(bias)) else $error("ramp jumped");
endmodule
`default_nettype wire

// ---- logic/tmc_core.sv ----
// Purpose: Transmit modulation control with APB register file
// Assumes: pclk acts as the reference oscillator; inputs synchronous to pclk
// Notes:   Analog quantities are presented as digital words
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tmc_core
   import tmc_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_tx_data_pin,
   output logic             bit_clock_pin,
   output logic             mod_data,
   output logic [1:0]       gauss_bt,
   output logic signed [TMC_FDEV_BITS:0] fdev_offset,
   output logic [TMC_SDM_BITS-1:0] step_divisor,
   output logic             low_power_amp,
   output logic             boost_amp_one,
   output logic             boost_amp_two,
   output logic [3:0]       amp_bias,
   output logic signed [7:0] output_power_dbm,
   output logic [7:0]       current_limit_ma,
   output logic             current_limit_on
);
   // Configuration registers
   logic [7:0] overcurrent_limit_ctrl;
   logic [7:0] high_power_pa_tune_a;
   logic [7:0] high_power_pa_tune_b;
   logic [7:0] br_msb;
   logic [7:0] br_lsb;
   logic [7:0] fdev_msb;
   logic [7:0] fdev_lsb;
   logic [7:0] ctrl;
   logic [7:0] shaping_ramp_register;
   logic [7:0] amp_level_register;
   logic       data_bit;

   function automatic logic [9:0] word_index(input logic [11:0] a);
      return a[11:2];
   endfunction

   // APB decode; zero wait states
   wire        acc      = psel && penable;
   wire        wr       = acc && pwrite;
   wire [9:0]  idx      = word_index(paddr);
   wire        aligned  = (paddr[1:0] == 2'b00);
   wire        hit_ocp  = idx == 10'(TMC_IDX_OCP);
   wire        hit_ta   = idx == 10'(TMC_IDX_TUNE_A);
   wire        hit_tb   = idx == 10'(TMC_IDX_TUNE_B);
   wire        hit_brm  = idx == 10'(TMC_IDX_BR_MSB);
   wire        hit_brl  = idx == 10'(TMC_IDX_BR_LSB);
   wire        hit_fdm  = idx == 10'(TMC_IDX_FDEV_MSB);
   wire        hit_fdl  = idx == 10'(TMC_IDX_FDEV_LSB);
   wire        hit_ctl  = idx == 10'(TMC_IDX_CTRL);
   wire        hit_rmp  = idx == 10'(TMC_IDX_RAMP);
   wire        hit_lvl  = idx == 10'(TMC_IDX_LEVEL);
   wire        hit_sts  = idx == 10'(TMC_IDX_STATUS);
   wire        mapped   = aligned && (hit_ocp || hit_ta || hit_tb || hit_brm || hit_brl
                          || hit_fdm || hit_fdl || hit_ctl || hit_rmp || hit_lvl || hit_sts);
   wire        wen      = wr && mapped;

   // Mode decode
   wire        tx_on    = ctrl[TMC_CTRL_TX];
   wire        cont     = ctrl[TMC_CTRL_CONT];
   wire        ook      = ctrl[TMC_CTRL_OOK];
   wire [1:0]  shaping_ramp_select = shaping_ramp_register[1:0];
   wire        gauss_on = !ook && (shaping_ramp_select != 2'b00);
   wire        sync_cont = cont && gauss_on;
   wire        timed    = tx_on && (!cont || gauss_on);
   wire [DIV_W-1:0] bit_rate_divisor = {br_msb, br_lsb};

   // Amplifier path selection
   wire        low_amp_enable       = amp_level_register[TMC_LVL_PA0];
   wire        boost_amp_one_enable = amp_level_register[TMC_LVL_PA1];
   wire        boost_amp_two_enable = amp_level_register[TMC_LVL_PA2];
   wire [2:0]  pa_bits = {low_amp_enable, boost_amp_one_enable, boost_amp_two_enable};
   wire [4:0]  output_power_level = amp_level_register[4:0];
   wire        hp_tuned = (high_power_pa_tune_a == TMC_HP_TUNE_A)
                       && (high_power_pa_tune_b == TMC_HP_TUNE_B);
   tmc_path_type path;
   assign path = (pa_bits == 3'b100) ? TMC_PATH_LOW
               : (pa_bits == 3'b010) ? TMC_PATH_ONE
               : (pa_bits == 3'b011) ? TMC_PATH_COMB : TMC_PATH_OFF;
   wire signed [7:0] path_ofs = (path != TMC_PATH_COMB) ? TMC_OFS_SINGLE
                              : hp_tuned ? TMC_OFS_HP : TMC_OFS_COMB;
   wire signed [7:0] next_power = path_ofs + $signed({3'b000, output_power_level});

   // Current limit
   wire [3:0]  current_limit_trim = overcurrent_limit_ctrl[3:0];
   wire [7:0]  next_limit = TMC_OCP_BASE_MA + 8'(TMC_OCP_STEP_MA * current_limit_trim);

   // Deviation, signed by current data bit
   wire [TMC_FDEV_BITS-1:0] fdev_word = {fdev_msb[5:0], fdev_lsb};
   wire signed [TMC_FDEV_BITS:0] next_fdev = data_bit
        ? $signed({1'b0, fdev_word}) : -$signed({1'b0, fdev_word});

   // Bit timing
   logic bit_tick;
   logic bit_clk;
   tmc_bit_timer #(.DIV_W(DIV_W)) u_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (timed),
      .divisor  (bit_rate_divisor),
      .bit_tick (bit_tick),
      .bit_clk  (bit_clk)
   );
   logic bit_clk_q;
   wire  bit_clk_rise = bit_clk && !bit_clk_q;

   // Data path: async mode passes the pin through, sync mode samples at clock rise
   wire next_data = (cont && !gauss_on) ? serial_tx_data_pin
                  : (sync_cont && bit_clk_rise) ? serial_tx_data_pin
                  : data_bit;

   // Keyed amplifier ramp
   logic [3:0] bias;
   tmc_ramp u_ramp (
      .pclk    (pclk),
      .presetn (presetn),
      .key_on  (tx_on && ook && data_bit && path != TMC_PATH_OFF),
      .smooth  (shaping_ramp_select != 2'b00),
      .bias    (bias)
   );

   wire [7:0] status = {4'h0, hp_tuned, path, data_bit};
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_ocp) rd_byte = overcurrent_limit_ctrl;
      if (hit_ta)  rd_byte = high_power_pa_tune_a;
      if (hit_tb)  rd_byte = high_power_pa_tune_b;
      if (hit_brm) rd_byte = br_msb;
      if (hit_brl) rd_byte = br_lsb;
      if (hit_fdm) rd_byte = fdev_msb;
      if (hit_fdl) rd_byte = fdev_lsb;
      if (hit_ctl) rd_byte = ctrl;
      if (hit_rmp) rd_byte = shaping_ramp_register;
      if (hit_lvl) rd_byte = amp_level_register;
      if (hit_sts) rd_byte = status;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overcurrent_limit_ctrl <= TMC_RST_OCP;
         high_power_pa_tune_a   <= TMC_RST_TUNE_A;
         high_power_pa_tune_b   <= TMC_RST_TUNE_B;
         br_msb                 <= TMC_RST_BR_MSB;
         br_lsb                 <= TMC_RST_BR_LSB;
         fdev_msb               <= TMC_RST_FDEV_MSB;
         fdev_lsb               <= TMC_RST_FDEV_LSB;
         ctrl                   <= 8'h00;
         shaping_ramp_register  <= 8'h00;
         amp_level_register     <= TMC_RST_LEVEL;
      end else if (wen) begin
         if (hit_ocp) overcurrent_limit_ctrl <= pwdata[7:0];
         if (hit_ta)  high_power_pa_tune_a   <= pwdata[7:0];
         if (hit_tb)  high_power_pa_tune_b   <= pwdata[7:0];
         if (hit_brm) br_msb                 <= pwdata[7:0];
         if (hit_brl) br_lsb                 <= pwdata[7:0];
         if (hit_fdm) fdev_msb               <= {2'b00, pwdata[5:0]};
         if (hit_fdl) fdev_lsb               <= pwdata[7:0];
         if (hit_ctl) ctrl                   <= {5'h00, pwdata[2:0]};
         if (hit_rmp) shaping_ramp_register  <= {6'h00, pwdata[1:0]};
         if (hit_lvl) amp_level_register     <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(aligned && (hit_ocp || hit_ta || hit_tb || hit_brm
                    || hit_brl || hit_fdm || hit_fdl || hit_ctl || hit_rmp || hit_lvl
                    || hit_sts));
         prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_bit         <= 1'b0;
         bit_clk_q        <= 1'b0;
         bit_clock_pin    <= 1'b0;
         mod_data         <= 1'b0;
         gauss_bt         <= 2'b00;
         fdev_offset      <= '0;
         step_divisor     <= '0;
         low_power_amp    <= 1'b0;
         boost_amp_one    <= 1'b0;
         boost_amp_two    <= 1'b0;
         amp_bias         <= 4'h0;
         output_power_dbm <= 8'sd0;
         current_limit_ma <= 8'd0;
         current_limit_on <= 1'b0;
      end else begin
         data_bit         <= next_data;
         bit_clk_q        <= bit_clk;
         bit_clock_pin    <= sync_cont && tx_on && bit_clk;
         mod_data         <= next_data;
         gauss_bt         <= gauss_on ? shaping_ramp_select : 2'b00;
         fdev_offset      <= (tx_on && !ook) ? next_fdev : '0;
         step_divisor     <= {1'b1, {(TMC_SDM_BITS-1){1'b0}}};
         low_power_amp    <= tx_on && path == TMC_PATH_LOW;
         boost_amp_one    <= tx_on && (path == TMC_PATH_ONE || path == TMC_PATH_COMB);
         boost_amp_two    <= tx_on && path == TMC_PATH_COMB;
         amp_bias         <= ook ? bias : ((tx_on && path != TMC_PATH_OFF) ? TMC_RAMP_STEPS
                                           : 4'h0);
         output_power_dbm <= next_power;
         current_limit_ma <= next_limit;
         current_limit_on <= overcurrent_limit_ctrl[TMC_OCP_ON];
      end
   end

   // Checks
   reserved_path_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(pa_bits inside {3'b100, 3'b010, 3'b011}) |=> !low_power_amp && !boost_amp_one
      && !boost_amp_two) else $error("reserved pattern enabled amplifier");
   path_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      tx_on && pa_bits == 3'b100 |=> low_power_amp && !boost_amp_one)
      else $error("low path not selected");
   power_offset_a: assert property (@(posedge pclk) disable iff (!presetn)
      path == TMC_PATH_COMB && !hp_tuned |=>
      output_power_dbm == -8'sd14 + $signed({3'b000, $past(output_power_level)}))
      else $error("combined offset wrong");
   current_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
      1 |=> current_limit_ma == 8'd45 + 8'd5 * {4'h0, $past(current_limit_trim)})
      else $error("current limit wrong");
   async_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      cont && !gauss_on |=> mod_data == $past(serial_tx_data_pin))
      else $error("async data not passed");
   sync_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_cont && !bit_clk_rise && $stable(ctrl) && $stable(shaping_ramp_register)
      |=> data_bit == $past(data_bit)) else $error("data changed off clock edge");
   no_clock_async_a: assert property (@(posedge pclk) disable iff (!presetn)
      !sync_cont |=> !bit_clock_pin) else $error("bit clock outside sync mode");
   fdev_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
      tx_on && !ook && data_bit |=> fdev_offset == $signed({1'b0, $past(fdev_word)}))
      else $error("deviation wrong");
   gauss_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      ook |=> gauss_bt == 2'b00) else $error("gaussian in keyed mode");
   step_a: assert property (@(posedge pclk) disable iff (!presetn)
      1 |=> step_divisor == 19'h40000) else $error("step divisor wrong");

   cov_sync_clock_c: cover property (@(posedge pclk) sync_cont && bit_clk_rise);
   cov_hp_path_c: cover property (@(posedge pclk) path == TMC_PATH_COMB && hp_tuned);
   cov_ook_ramp_c: cover property (@(posedge pclk) ook && amp_bias == TMC_RAMP_STEPS);
   cov_apb_err_c: cover property (@(posedge pclk) pready && pslverr);
endmodule
`default_nettype wire

// ---- testbench/tmc_host_model.sv ----
// Purpose: Host side of the serial transmit data link
// Assumes: Host runs on pclk; sync_mode says whether the device paces the data
// Notes:   In paced mode the host flips its bit after each bit clock rise
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
   input  wire logic pclk,
   input  wire logic sync_mode,
   input  wire logic want_bit,
   input  wire logic bit_clock_pin,
   output var  logic serial_tx_data_pin
);
   logic clk_q;

   initial begin
      serial_tx_data_pin = 1'b0;
      clk_q = 1'b0;
   end

   always @(posedge pclk) begin
      // In paced mode change only after a seen rise, so the next sample finds a settled bit; otherwise follow want_bit
      if (sync_mode) begin
         if (bit_clock_pin && !clk_q) begin
            serial_tx_data_pin <= ~serial_tx_data_pin;
         end
      end else begin
         serial_tx_data_pin <= want_bit;
      end
      clk_q <= bit_clock_pin;
   end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the transmit modulation control block
// Assumes: APB master tasks, one host model on the serial data link
// Notes:   Bit divisor is set small so the paced link runs quickly
`timescale 1ns/1ps
`default_nettype none
module tb
   import tmc_pkg::*;
;
   logic                          pclk, presetn, psel, penable, pwrite;
   logic [11:0]                   paddr;
   logic [31:0]                   pwdata, prdata, rd;
   logic                          pready, pslverr, er, m0;
   logic                          serial_tx_data_pin, bit_clock_pin, mod_data;
   logic [1:0]                    gauss_bt;
   logic signed [TMC_FDEV_BITS:0] fdev_offset;
   logic [TMC_SDM_BITS-1:0]       step_divisor;
   logic                          low_power_amp, boost_amp_one, boost_amp_two;
   logic [3:0]                    amp_bias;
   logic signed [7:0]             output_power_dbm;
   logic [7:0]                    current_limit_ma;
   logic                          current_limit_on, want_bit, sync_mode;
   logic [7:0]                    idx_t [8];
   logic [7:0]                    rst_t [8];
   logic [2:0]                    exp_p;
   int                            n_mismatch, checks_done, n;

   tmc_core #(.DIV_W(16)) tmc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_tx_data_pin(serial_tx_data_pin),
      .bit_clock_pin(bit_clock_pin), .mod_data(mod_data), .gauss_bt(gauss_bt),
      .fdev_offset(fdev_offset), .step_divisor(step_divisor), .low_power_amp(low_power_amp),
      .boost_amp_one(boost_amp_one), .boost_amp_two(boost_amp_two), .amp_bias(amp_bias),
      .output_power_dbm(output_power_dbm), .current_limit_ma(current_limit_ma),
      .current_limit_on(current_limit_on));

   tmc_host_model tmc_host_model_inst (.pclk(pclk), .sync_mode(sync_mode),
      .want_bit(want_bit), .bit_clock_pin(bit_clock_pin),
      .serial_tx_data_pin(serial_tx_data_pin));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Holds the access until pready is seen high at a rising edge, then takes the answer there
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h0, d});
   endtask

   task automatic restart(input logic [7:0] ctrl);
      wr(TMC_IDX_CTRL, 8'h00);
      wr(TMC_IDX_CTRL, ctrl);
      repeat (4) @(negedge pclk);
   endtask

   task automatic wait_rise(output int cnt);
      cnt = 0;
      while (bit_clock_pin === 1'b1 && cnt < 100) begin @(negedge pclk); cnt++; end
      while (bit_clock_pin !== 1'b1 && cnt < 100) begin @(negedge pclk); cnt++; end
   endtask

   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      n_mismatch++;
      close_out();
   end

   initial begin
      {presetn, psel, penable, pwrite, want_bit, sync_mode} = 6'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      idx_t = '{TMC_IDX_OCP, TMC_IDX_TUNE_A, TMC_IDX_TUNE_B, TMC_IDX_BR_MSB,
                TMC_IDX_BR_LSB, TMC_IDX_FDEV_MSB, TMC_IDX_FDEV_LSB, TMC_IDX_LEVEL};
      rst_t = '{TMC_RST_OCP, TMC_RST_TUNE_A, TMC_RST_TUNE_B, TMC_RST_BR_MSB,
                TMC_RST_BR_LSB, TMC_RST_FDEV_MSB, TMC_RST_FDEV_LSB, TMC_RST_LEVEL};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, idx_t[i], 32'h0);
         chk("reset value", {er, rd[7:0]}, {1'b0, rst_t[i]});
      end
      chk("step divisor", step_divisor, 32'h40000);
      chk("reset limit", current_limit_ma, 32'd95);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped read", rd, 32'h0);
      chk("unmapped error", er, 32'd1);
      foreach (rst_t[i]) begin
         wr(TMC_IDX_OCP, 8'h10 | (8'(i) * 8'd2));
         repeat (3) @(negedge pclk);
         chk("current limit", current_limit_ma, 32'd45 + 32'd10 * 32'(i));
         chk("limit on", current_limit_on, 32'd1);
      end
      wr(TMC_IDX_OCP, 8'h0F);
      repeat (3) @(negedge pclk);
      chk("limit off", current_limit_on, 32'd0);
      restart(8'h01);
      for (int p = 0; p < 8; p++) begin
         wr(TMC_IDX_LEVEL, {3'(p), 5'd20});
         repeat (3) @(negedge pclk);
         exp_p = (p == 4) ? 3'b100 : (p == 2) ? 3'b010 : (p == 3) ? 3'b011 : 3'b000;
         chk("amp path", {low_power_amp, boost_amp_one, boost_amp_two}, exp_p);
         if (exp_p != 3'b000) begin
            chk("power", output_power_dbm, (p == 3) ? 32'd6 : 32'd2);
         end
      end
      wr(TMC_IDX_LEVEL, {3'b011, 5'd20});
      wr(TMC_IDX_TUNE_A, TMC_HP_TUNE_A);
      wr(TMC_IDX_TUNE_B, TMC_HP_TUNE_B);
      repeat (3) @(negedge pclk);
      chk("high power", output_power_dbm, 32'd9);
      wr(TMC_IDX_TUNE_A, 8'h55);
      wr(TMC_IDX_TUNE_B, 8'h70);
      wr(TMC_IDX_OCP, 8'h1A);
      wr(TMC_IDX_LEVEL, 8'h9F);
      restart(8'h03);
      for (int b = 0; b < 3; b++) begin
         want_bit <= b[0] ^ 1'b1;
         repeat (4) @(negedge pclk);
         chk("async data", mod_data, {31'h0, ~b[0]});
         chk("deviation", 32'(fdev_offset), b[0] ? 32'hFFFFFFAE : 32'h52);
         chk("no bit clock", bit_clock_pin, 32'd0);
      end
      for (int r = 1; r < 4; r++) begin
         wr(TMC_IDX_RAMP, 8'(r));
         restart(8'h03);
         chk("gauss select", gauss_bt, 32'(r));
      end
      wr(TMC_IDX_BR_MSB, 8'h00);
      wr(TMC_IDX_BR_LSB, 8'h08);
      restart(8'h03);
      sync_mode <= 1'b1;
      wait_rise(n);
      wait_rise(n);
      m0 = mod_data;
      wait_rise(n);
      chk("bit period", n, 32'd8);
      chk("paced data", mod_data ^ m0, 32'd1);
      sync_mode <= 1'b0;
      want_bit <= 1'b0;
      wr(TMC_IDX_RAMP, 8'h00);
      restart(8'h07);
      chk("keyed off", {fdev_offset, amp_bias}, 32'h0);
      want_bit <= 1'b1;
      repeat (4) @(negedge pclk);
      chk("keyed on", amp_bias, 32'd15);
      want_bit <= 1'b0;
      wr(TMC_IDX_RAMP, 8'h01);
      restart(8'h07);
      repeat (20) @(negedge pclk);
      want_bit <= 1'b1;
      n = 0;
      while (amp_bias === 4'h0 && n < 40) begin @(negedge pclk); n++; end
      chk("ramp start", amp_bias, 32'd1);
      repeat (16) @(negedge pclk);
      chk("ramp top", amp_bias, 32'd15);
      close_out();
   end
endmodule
`default_nettype wire
